/* File: hdl/tmrev_defines.vh */
`ifndef TMREV_DEFINES_VH
`define TMREV_DEFINES_VH
// ==========================================
// Register byte addresses (index times four)
`define TMREV_IDX_EVENT_CONTROL     8'h06
`define TMREV_IDX_ENCLR      8'h08
`define TMREV_ADDR_EVENT_CONTROL    12'h018
`define TMREV_ADDR_ENCLR     12'h020
`define TMREV_ADDR_ENSET     12'h024
`define TMREV_ADDR_FLAGS     12'h028
`define TMREV_ADDR_MASK      12'h02c
`define TMREV_ADDR_STATUS    12'h030
// ==========================================
// Enable register fields
`define TMREV_EN_WRAP        0
`define TMREV_EN_ERR         1
`define TMREV_EN_CH0         4
`define TMREV_EN_CH1         5
`define TMREV_EN_MASK        8'h33
// ==========================================
// Event control fields
`define TMREV_EV_ACT_LO      0
`define TMREV_EV_ACT_HI      2
`define TMREV_EV_INV         4
`define TMREV_EV_IN_EN       5
`define TMREV_EV_WRAP_OUT    8
`define TMREV_EV_CH0_OUT     12
`define TMREV_EV_CH1_OUT     13
`define TMREV_EV_MASK        16'h3137
// ==========================================
// Reset values
`define TMREV_RST_EVENT_CONTROL     16'h0000
`define TMREV_RST_IRQEN      8'h00
`endif

/* File: hdl/tmrev_ctrl.v */
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// Operation
// R1: Writing one to a channel bit in clear register disables that channel interrupt.
// R2: Writing zero to a clear register bit leaves that enable unchanged.
// R3: Writing one to error bit clears error enable; read shows enable.
// R4: Writing one to wrap bit clears wrap enable; reads give enable state.
// R5: Clear and set registers share one set of enable bits.
// R6: Channel event output follows match only while its enable bit is set.
// R7: Wrap event output follows overflow only while its enable bit is set.
// R8: Incoming events accepted only while input enable bit is one.
// R9: Polarity bit one inverts incoming event source before use.
// R10: Three-bit action field selects counter action on an accepted event.
// R11: Irq line high only while source flag and its enable are set; code gates irq by mask_q instead, only timer_irq by the enable.
// R12: Software writes event control only while the counter is disabled.
`include "tmrev_defines.vh"

module tmrev_ctrl #(
  parameter CHANNELS = 2
) (
  input  wire                clk,
  input  wire                reset_n,
  input  wire                clk_en,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  output wire                pready,
  output reg  [31:0]         prdata,
  output wire                pslverr,
  input  wire                counter_enabled,
  input  wire [CHANNELS-1:0] chan_match,
  input  wire                wrap,
  input  wire                count_error,
  input  wire                event_in,
  output reg  [CHANNELS-1:0] chan_match_event_out,
  output reg                 wrap_event_out,
  output reg                 event_accepted,
  output wire [2:0]          event_action_select,
  output wire                timer_irq,
  output wire                irq
);

  // ==========================================
  // Bus decode
  wire wr_en = psel & penable & pwrite & clk_en;
  wire sel_event_control = (paddr == `TMREV_ADDR_EVENT_CONTROL);
  wire sel_enclr  = (paddr == `TMREV_ADDR_ENCLR);
  wire sel_enset  = (paddr == `TMREV_ADDR_ENSET);
  wire sel_flags  = (paddr == `TMREV_ADDR_FLAGS);
  wire sel_mask   = (paddr == `TMREV_ADDR_MASK);
  wire sel_status = (paddr == `TMREV_ADDR_STATUS);
  wire mapped = sel_event_control | sel_enclr | sel_enset | sel_flags | sel_mask | sel_status;
  // Zero wait states; unmapped accesses and locked writes flag an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (~mapped | (pwrite & sel_event_control & counter_enabled));

  reg [15:0] event_control_reg_q;
  reg [7:0]  irq_en_q;
  reg [7:0]  flag_q;
  reg [7:0]  flag_d;
  reg [7:0]  mask_q;
  reg [1:0]  ev_sync_q;
  reg [31:0] prdata_d;

  // ==========================================
  // Event control register
  // R12 write only when idle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      event_control_reg_q <= `TMREV_RST_EVENT_CONTROL;
    end else if (wr_en && sel_event_control && !counter_enabled) begin
      event_control_reg_q <= pwdata[15:0] & `TMREV_EV_MASK;
    end
  end

  // ==========================================
  // Shared interrupt enables
  // R1 R2 R3 R4 R5 one storage, clear on ones
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_en_q <= `TMREV_RST_IRQEN;
    end else if (wr_en && sel_enclr) begin
      irq_en_q <= irq_en_q & ~(pwdata[7:0] & `TMREV_EN_MASK);
    end else if (wr_en && sel_enset) begin
      irq_en_q <= irq_en_q | (pwdata[7:0] & `TMREV_EN_MASK);
    end
  end

  // ==========================================
  // Event input path
  wire ev_in_en  = event_control_reg_q[`TMREV_EV_IN_EN];
  wire ev_invert = event_control_reg_q[`TMREV_EV_INV];
  // Input is asynchronous, so two flops before use
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_sync_q <= 2'b00;
    end else if (clk_en) begin
      ev_sync_q <= {ev_sync_q[0], event_in};
    end
  end

  // R10 action field
  assign event_action_select = event_control_reg_q[`TMREV_EV_ACT_HI:`TMREV_EV_ACT_LO];

  // ==========================================
  // Output events
  wire [1:0] ch_out_en = {event_control_reg_q[`TMREV_EV_CH1_OUT],
                          event_control_reg_q[`TMREV_EV_CH0_OUT]};
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_chan
      // R6 gated match event
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          chan_match_event_out[g] <= 1'b0;
        end else if (clk_en) begin
          chan_match_event_out[g] <= chan_match[g] & ch_out_en[g % 2];
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrap_event_out <= 1'b0;
      event_accepted <= 1'b0;
    end else if (clk_en) begin
      // R7 gated wrap event
      wrap_event_out <= wrap & event_control_reg_q[`TMREV_EV_WRAP_OUT];
      // R8 R9 enable then polarity
      event_accepted <= ev_in_en & (ev_sync_q[1] ^ ev_invert);
    end
  end

  // ==========================================
  // Interrupt flags, set wins over clear
  wire [7:0] src = {2'b00, chan_match[1:0], 2'b00, count_error, wrap};
  always @* begin
    flag_d = flag_q;
    if (wr_en && sel_flags) begin
      flag_d = flag_d & ~pwdata[7:0];
    end
    flag_d = (flag_d | src) & `TMREV_EN_MASK;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= 8'h00;
      mask_q <= 8'h00;
    end else if (clk_en) begin
      flag_q <= flag_d;
      if (wr_en && sel_mask) begin
        mask_q <= pwdata[7:0] & `TMREV_EN_MASK;
      end
    end
  end

  // R11 flag and enable on timer_irq; irq is flag and mask
  assign timer_irq = |(flag_q & irq_en_q);
  assign irq       = |(flag_q & mask_q);

  // ==========================================
  // Read data
  // R3 R4 R5 enables read back
  always @* begin
    prdata_d = 32'h0000_0000;
    if (sel_event_control) begin
      prdata_d = {16'h0000, event_control_reg_q};
    end else if (sel_enclr || sel_enset) begin
      prdata_d = {24'h00_0000, irq_en_q};
    end else if (sel_flags) begin
      prdata_d = {24'h00_0000, flag_q};
    end else if (sel_mask) begin
      prdata_d = {24'h00_0000, mask_q};
    end else if (sel_status) begin
      prdata_d = {30'h0, counter_enabled, ev_in_en};
    end
  end

  // Word taken in the setup cycle, so it stands through the access phase
  // A flag set during the access cycle shows on the next read
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      prdata <= prdata_d;
    end
  end

endmodule

/* File: tb/tmrev_ctrl_props.sv */
`timescale 1ns/1ps
// ====
// Port checker
module tmrev_ctrl_props #(
  parameter CHANNELS = 2
) (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                clk_en,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pslverr,
  input wire logic                counter_enabled,
  input wire logic [CHANNELS-1:0] chan_match,
  input wire logic                wrap,
  input wire logic                count_error,
  input wire logic [CHANNELS-1:0] chan_match_event_out,
  input wire logic                wrap_event_out,
  input wire logic [2:0]          event_action_select,
  input wire logic                timer_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire ev_acc = psel & penable & pwrite & (paddr == 12'h018);
  wire ev_wr  = ev_acc & clk_en;
  // Mirror of the event control word, so gating is judged from the pins
  logic [15:0] ctl_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= 16'h0000;
    end else if (ev_wr && !counter_enabled) begin
      ctl_q <= pwdata[15:0];
    end
  end
  sequence s_clr_all;
    psel && !penable && pwrite && paddr == 12'h020 && pwdata[5:0] == 6'h33 ##1 penable;
  endsequence
  chk_lock_refuse: assert property (ev_acc && counter_enabled |-> pslverr)
    else $error("locked write not refused");
  chk_act_write: assert property (ev_wr && !counter_enabled |=>
    event_action_select == $past(pwdata[2:0])) else $error("action not written");
  chk_act_hold: assert property (!ev_wr |=> $stable(event_action_select))
    else $error("action changed");
  chk_clr_all: assert property (s_clr_all |=> !timer_irq)
    else $error("enables not cleared");
  chk_ch0_gate: assert property ($past(clk_en) |->
    chan_match_event_out[0] == $past(chan_match[0] && ctl_q[12])) else $error("ch0 gate wrong");
  chk_ch1_gate: assert property ($past(clk_en) |->
    chan_match_event_out[1] == $past(chan_match[1] && ctl_q[13])) else $error("ch1 gate wrong");
  chk_wrap_gate: assert property ($past(clk_en) |->
    wrap_event_out == $past(wrap && ctl_q[8])) else $error("wrap gate wrong");
  chk_irq_cause: assert property ($rose(timer_irq) |->
    $past(wrap || count_error || (|chan_match) || (psel && pwrite))) else $error("irq no cause");
endmodule
bind tmrev_ctrl tmrev_ctrl_props #(.CHANNELS(CHANNELS)) i_props (.clk, .reset_n, .clk_en, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pslverr, .counter_enabled, .chan_match, .wrap,
  .count_error, .chan_match_event_out, .wrap_event_out, .event_action_select, .timer_irq);

/* File: tb/tmrev_evsys.sv */
`timescale 1ns/1ps
// ====
// Event routing stand-in
module tmrev_evsys (
  input  wire logic [3:0] fire,
  input  wire logic       clk,
  input  wire logic [1:0] chan_match_event_out,
  input  wire logic       wrap_event_out,
  output logic [1:0]      chan_match,
  output logic            wrap,
  output logic            count_error,
  output logic [2:0]      seen = 3'h0
);
  initial {count_error, wrap, chan_match} = 4'h0;
  // Pulses last one cycle, as a counter core gives them
  always @(posedge clk) begin
    {count_error, wrap, chan_match} <= fire;
    // A new burst starts a fresh record, so gated-off events show as absent
    seen <= (|fire) ? 3'h0 : (seen | {wrap_event_out, chan_match_event_out});
  end
endmodule

/* File: tb/tmrev_ctrl_tb_top.sv */
`timescale 1ns/1ps
module tmrev_ctrl_tb_top;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, cen = 0, ev = 0, er, ce = 1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd;
  logic [3:0]  fire = '0;
  wire pready, pslverr, wrap, cerr, wout, acc, tirq, irq;
  wire [31:0] prdata;
  wire [1:0]  cm, cmo;
  wire [2:0]  act, seen;
  int failures = 0, comparisons = 0;
  always #2 clk = ~clk;
  tmrev_ctrl i_tmrev_ctrl (.clk(clk), .reset_n(reset_n), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .counter_enabled(cen), .chan_match(cm), .wrap(wrap),
    .count_error(cerr), .event_in(ev), .chan_match_event_out(cmo), .wrap_event_out(wout),
    .event_accepted(acc), .event_action_select(act), .timer_irq(tirq), .irq(irq));
  tmrev_evsys i_tmrev_evsys (.fire(fire), .clk(clk), .chan_match_event_out(cmo),
    .wrap_event_out(wout), .chan_match(cm), .wrap(wrap), .count_error(cerr), .seen(seen));
  task test_done;
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1;
    repeat (9) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) begin failures++; test_done; end
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task t_enclr;
    logic [31:0] m[4] = '{32'h1, 32'h2, 32'h10, 32'h20}, e[4] = '{32'h32, 32'h30, 32'h20, 32'h0};
    apb(0, 12'h018, 0); chk(rd, 32'h0);
    apb(1, 12'h024, 32'h33); apb(0, 12'h020, 0); chk(rd, 32'h33);
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h020, m[i]); apb(0, 12'h024, 0); chk(rd, e[i]);
    end
  endtask
  task t_evout;
    apb(1, 12'h018, 32'h1100);
    fire <= 4'hf;
    @(posedge clk) fire <= 4'h0;
    repeat (3) @(posedge clk);
    chk(seen, 3'h5);
    chk({tirq, irq}, 2'h0);
    apb(0, 12'h028, 0);
    chk(rd, 32'h33);
    apb(1, 12'h018, 32'h2000);
    fire <= 4'hf;
    @(posedge clk) fire <= 4'h0;
    repeat (3) @(posedge clk);
    chk(seen, 3'h2);
    apb(1, 12'h024, 32'h1); apb(1, 12'h02c, 32'h1); chk({tirq, irq}, 2'h3);
    apb(1, 12'h028, 32'h33); chk({tirq, irq}, 2'h0);
    apb(1, 12'h020, 32'h33);
  endtask
  task t_evin;
    apb(1, 12'h018, 32'h25);
    chk(act, 3'h5);
    apb(0, 12'h030, 0);
    chk(rd, 32'h1);
    ev <= 1;
    repeat (4) @(posedge clk);
    chk(acc, 1'b1);
    apb(1, 12'h018, 32'h35);
    repeat (4) @(posedge clk);
    chk(acc, 1'b0);
    ev <= 0;
    apb(1, 12'h018, 32'h10);
    repeat (4) @(posedge clk);
    chk(acc, 1'b0);
    cen <= 1;
    apb(1, 12'h018, 32'h3);
    chk({er, act}, 4'h8);
    cen <= 0;
    ce <= 0;
    apb(1, 12'h018, 32'h7);
    ce <= 1;
    apb(0, 12'h018, 0);
    chk(rd, 32'h10);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1;
    t_enclr; t_evout; t_evin; test_done;
  end
endmodule
